/* hdl/outport_pkg.sv */
// Shared constants and carrier types for the output port block
package outport_pkg;

    // ----------------------------------------------------------------
    // Bus widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 4;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CLOCK_OUT_CONTROL_ADDR       = 16'hFF06;
    localparam logic [ADDR_W-1:0] LOW_PORT_FLOAT_CONTROL_ADDR  = 16'hFF30;
    localparam logic [ADDR_W-1:0] LOW_PORT_OUTPUT_DATA_ADDR    = 16'hFF31;
    localparam logic [ADDR_W-1:0] HIGH_PORT_FLOAT_CONTROL_ADDR = 16'hFF32;
    localparam logic [ADDR_W-1:0] TIMER_OUT_CONTROL_ADDR       = 16'hFFC1;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FREQ_SELECT_LO_POS  = 0;
    localparam int FREQ_SELECT_HI_POS  = 1;
    localparam int SPARE_STORAGE_POS   = 2;
    localparam int FREQ_CLOCK_EN_POS   = 3;
    localparam int UPPER_FLOAT_POS     = 0;
    localparam int TIMER_CLOCK_EN_POS  = 0;
    localparam int TIMER_PIN_POS       = 2;
    localparam int FREQ_PIN_POS        = 3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] CLOCK_OUT_CONTROL_RST       = 4'h0;
    localparam logic [DATA_W-1:0] LOW_PORT_FLOAT_CONTROL_RST  = 4'h0;
    localparam logic [DATA_W-1:0] LOW_PORT_OUTPUT_DATA_RST    = 4'h0;
    localparam logic [DATA_W-1:0] HIGH_PORT_FLOAT_CONTROL_RST = 4'h0;
    localparam logic [DATA_W-1:0] TIMER_OUT_CONTROL_RST       = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO                   = 4'h0;

    // ----------------------------------------------------------------
    // Slow clock division ratios
    // ----------------------------------------------------------------
    localparam int SLOW_DIV_SHORT = 8;
    localparam int SLOW_DIV_LONG  = 64;

    // ----------------------------------------------------------------
    // Frequency select codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        FSEL_SLOW_DIV64 = 2'h0,
        FSEL_SLOW_DIV8  = 2'h1,
        FSEL_SLOW       = 2'h2,
        FSEL_FAST       = 2'h3
    } freq_select_e;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    typedef struct packed {
        logic [3:0] level;
        logic [3:0] drive;
    } pin_group_s;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] target);
        addr_hit = (addr == target);
    endfunction

endpackage

/* hdl/slow_clock_divider.sv */
// Divides the sampled slow oscillator clock into its /8 and /64 taps
module slow_clock_divider #(
    parameter int SHORT_RATIO = outport_pkg::SLOW_DIV_SHORT,
    parameter int LONG_RATIO  = outport_pkg::SLOW_DIV_LONG
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic slow_rise,
    output logic      div_short,
    output logic      div_long
);
    import outport_pkg::*;

    localparam int CNT_W     = $clog2(LONG_RATIO);
    localparam int SHORT_TAP = $clog2(SHORT_RATIO) - 1;
    localparam int LONG_TAP  = CNT_W - 1;

    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;

    // ----------------------------------------------------------------
    // Edge counter
    // ----------------------------------------------------------------
    // Power-of-two ratios give square taps straight off the counter bits
    assign nxt_count = slow_rise ? count_ff + CNT_W'(1) : count_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else if (clk_en) begin
            count_ff <= nxt_count;
        end
    end

    assign div_short = count_ff[SHORT_TAP];
    assign div_long  = count_ff[LONG_TAP];

endmodule

/* hdl/output_port_special_clock_out.sv */
// Eight-bit general output port with timer and oscillator clock outputs
//
// Overview of operation
// - Reset clears all data and float bits, so every low pin drives low.
// - Special output with data bit zero drives a constant low.
// - Float bit one releases the pin, even with clock output selected.
// - Port bit 2 carries timer clock when enabled, data one, float zero.
// - Port bit 3 carries selected oscillator clock when frequency output enabled.
// - Select 11 fast, 10 slow, 01 slow/8, 00 slow/64.
// - Float register bits 3..0 control low pins, reset zero, readable.
// - Data register bits 3..0 set low pin levels, reset zero, readable.
// - Upper float bit one releases all four upper pins, zero drives them.
// - Frequency enable cleared, bit 3 drives a steady low.
// - Timer enable cleared, bit 2 drives its data bit as a steady level.
//
// Decided for this implementation: the strobed register port.
module output_port_special_clock_out (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic                     clk_en,
    input  wire outport_pkg::reg_req_s    reg_req,
    output logic [outport_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                     timer_clock_output,
    input  wire logic                     slow_osc_clock,
    input  wire logic                     fast_osc_clock,
    input  wire logic [3:0]               upper_nibble_data,
    output outport_pkg::pin_group_s       low_pins,
    output outport_pkg::pin_group_s       upper_nibble_outputs
);
    import outport_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] clock_out_control_ff;
    logic [DATA_W-1:0] low_port_float_control_ff;
    logic [DATA_W-1:0] low_port_output_data_ff;
    logic              upper_nibble_float_ff;
    logic              timer_clock_out_enable_ff;
    logic [DATA_W-1:0] rdata_ff;

    logic [DATA_W-1:0] nxt_clock_out_control;
    logic [DATA_W-1:0] nxt_low_port_float_control;
    logic [DATA_W-1:0] nxt_low_port_output_data;
    logic              nxt_upper_nibble_float;
    logic              nxt_timer_clock_out_enable;
    logic [DATA_W-1:0] nxt_rdata;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire hit_clock_ctl   = addr_hit(reg_req.addr, CLOCK_OUT_CONTROL_ADDR);
    wire hit_low_float   = addr_hit(reg_req.addr, LOW_PORT_FLOAT_CONTROL_ADDR);
    wire hit_low_data    = addr_hit(reg_req.addr, LOW_PORT_OUTPUT_DATA_ADDR);
    wire hit_high_float  = addr_hit(reg_req.addr, HIGH_PORT_FLOAT_CONTROL_ADDR);
    wire hit_timer_ctl   = addr_hit(reg_req.addr, TIMER_OUT_CONTROL_ADDR);

    wire wr_clock_ctl    = reg_req.wr & hit_clock_ctl;
    wire wr_low_float    = reg_req.wr & hit_low_float;
    wire wr_low_data     = reg_req.wr & hit_low_data;
    wire wr_high_float   = reg_req.wr & hit_high_float;
    wire wr_timer_ctl    = reg_req.wr & hit_timer_ctl;

    // ----------------------------------------------------------------
    // Register next values
    // ----------------------------------------------------------------
    // Spare bit is stored with the rest but feeds nothing downstream
    assign nxt_clock_out_control = wr_clock_ctl ? reg_req.wdata
                                                : clock_out_control_ff;
    assign nxt_low_port_float_control = wr_low_float ? reg_req.wdata
                                                     : low_port_float_control_ff;
    assign nxt_low_port_output_data = wr_low_data ? reg_req.wdata
                                                  : low_port_output_data_ff;
    // Only the lowest bit exists; the rest are dropped on write
    assign nxt_upper_nibble_float = wr_high_float ? reg_req.wdata[UPPER_FLOAT_POS]
                                                  : upper_nibble_float_ff;
    assign nxt_timer_clock_out_enable = wr_timer_ctl ? reg_req.wdata[TIMER_CLOCK_EN_POS]
                                                     : timer_clock_out_enable_ff;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [DATA_W-1:0] rd_high_float = {3'h0, upper_nibble_float_ff};
    wire [DATA_W-1:0] rd_timer_ctl  = {3'h0, timer_clock_out_enable_ff};

    wire [DATA_W-1:0] rd_select =
        hit_clock_ctl  ? clock_out_control_ff :
        hit_low_float  ? low_port_float_control_ff :
        hit_low_data   ? low_port_output_data_ff :
        hit_high_float ? rd_high_float :
        hit_timer_ctl  ? rd_timer_ctl :
                         READ_ZERO;

    // Data valid only in the cycle after the strobe, zero otherwise
    assign nxt_rdata = reg_req.rd ? rd_select : READ_ZERO;

    // ----------------------------------------------------------------
    // Register flops
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clock_out_control_ff      <= CLOCK_OUT_CONTROL_RST;
            low_port_float_control_ff <= LOW_PORT_FLOAT_CONTROL_RST;
            low_port_output_data_ff   <= LOW_PORT_OUTPUT_DATA_RST;
            upper_nibble_float_ff     <= HIGH_PORT_FLOAT_CONTROL_RST[UPPER_FLOAT_POS];
            timer_clock_out_enable_ff <= TIMER_OUT_CONTROL_RST[TIMER_CLOCK_EN_POS];
        end else if (clk_en) begin
            clock_out_control_ff      <= nxt_clock_out_control;
            low_port_float_control_ff <= nxt_low_port_float_control;
            low_port_output_data_ff   <= nxt_low_port_output_data;
            upper_nibble_float_ff     <= nxt_upper_nibble_float;
            timer_clock_out_enable_ff <= nxt_timer_clock_out_enable;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_ff <= READ_ZERO;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // ----------------------------------------------------------------
    // Field views
    // ----------------------------------------------------------------
    wire          freq_clock_out_enable = clock_out_control_ff[FREQ_CLOCK_EN_POS];
    wire          timer_clock_out_enable = timer_clock_out_enable_ff;
    wire          freq_select_lo        = clock_out_control_ff[FREQ_SELECT_LO_POS];
    wire          freq_select_hi        = clock_out_control_ff[FREQ_SELECT_HI_POS];
    wire          port_bit2_data        = low_port_output_data_ff[TIMER_PIN_POS];
    wire          port_bit3_data        = low_port_output_data_ff[FREQ_PIN_POS];
    freq_select_e freq_select;

    assign freq_select = freq_select_e'({freq_select_hi, freq_select_lo});

    // ----------------------------------------------------------------
    // Clock input synchronisers
    // ----------------------------------------------------------------
    // The fast oscillator is only sampled here; above half the system
    // rate its copy on the pin is aliased, so keep it well below 50 MHz
    logic [2:0] clk_meta_ff;
    logic [2:0] clk_sync_ff;
    logic       slow_prev_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clk_meta_ff  <= 3'h0;
            clk_sync_ff  <= 3'h0;
            slow_prev_ff <= 1'b0;
        end else if (clk_en) begin
            clk_meta_ff  <= {fast_osc_clock, slow_osc_clock, timer_clock_output};
            clk_sync_ff  <= clk_meta_ff;
            slow_prev_ff <= clk_sync_ff[1];
        end
    end

    wire timer_clk_sync = clk_sync_ff[0];
    wire slow_clk_sync  = clk_sync_ff[1];
    wire fast_clk_sync  = clk_sync_ff[2];
    wire slow_rise      = slow_clk_sync & ~slow_prev_ff;

    // ----------------------------------------------------------------
    // Slow clock division
    // ----------------------------------------------------------------
    logic slow_div8;
    logic slow_div64;

    slow_clock_divider #(
        .SHORT_RATIO (SLOW_DIV_SHORT),
        .LONG_RATIO  (SLOW_DIV_LONG)
    ) u_slow_div (
        .clock     (clock),
        .rst       (rst),
        .clk_en    (clk_en),
        .slow_rise (slow_rise),
        .div_short (slow_div8),
        .div_long  (slow_div64)
    );

    // ----------------------------------------------------------------
    // Frequency clock select
    // ----------------------------------------------------------------
    logic freq_clock_output;

    always_comb begin
        unique case (freq_select)
            FSEL_FAST:       freq_clock_output = fast_clk_sync;
            FSEL_SLOW:       freq_clock_output = slow_clk_sync;
            FSEL_SLOW_DIV8:  freq_clock_output = slow_div8;
            FSEL_SLOW_DIV64: freq_clock_output = slow_div64;
        endcase
    end

    // ----------------------------------------------------------------
    // Special pin levels
    // ----------------------------------------------------------------
    // Enables gate the live clock with no phase alignment, so a runt
    // pulse can appear when they switch; a clean gate was not required
    wire timer_pin_src = timer_clock_out_enable ? timer_clk_sync
                                                : 1'b1;
    wire freq_pin_src  = freq_clock_out_enable ? freq_clock_output
                                               : 1'b0;

    // Data bit zero forces low whatever the special selection
    wire port_bit2_level = port_bit2_data & timer_pin_src;
    wire port_bit3_level = port_bit3_data & freq_pin_src;

    wire [3:0] nxt_low_level = {port_bit3_level,
                                port_bit2_level,
                                low_port_output_data_ff[1:0]};
    // Float one releases the pin, clock output or not
    wire [3:0] nxt_low_drive = ~low_port_float_control_ff;
    wire [3:0] nxt_high_drive = {4{~upper_nibble_float_ff}};

    // ----------------------------------------------------------------
    // Pin flops
    // ----------------------------------------------------------------
    pin_group_s low_pins_ff;
    pin_group_s high_pins_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            low_pins_ff  <= '{level: 4'h0, drive: 4'hF};
            high_pins_ff <= '{level: 4'h0, drive: 4'hF};
        end else if (clk_en) begin
            low_pins_ff  <= '{level: nxt_low_level, drive: nxt_low_drive};
            high_pins_ff <= '{level: upper_nibble_data, drive: nxt_high_drive};
        end
    end

    assign low_pins             = low_pins_ff;
    assign upper_nibble_outputs = high_pins_ff;

endmodule

/* testbench/outport_monitor.sv */
// Checker for the output port block, bound to its top module
module outport_monitor
    import outport_pkg::*;
(
    input wire logic                           clock,
    input wire logic                           rst,
    input wire logic                           clk_en,
    input wire outport_pkg::reg_req_s          reg_req,
    input wire logic [outport_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                           timer_clock_output,
    input wire logic                           slow_osc_clock,
    input wire logic                           fast_osc_clock,
    input wire logic [3:0]                     upper_nibble_data,
    input wire outport_pkg::pin_group_s        low_pins,
    input wire outport_pkg::pin_group_s        upper_nibble_outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Shadow registers
    // ----------------------------------------------------------------
    // Shadows let pin checks stay independent of the design's registers
    logic       ok_ff;
    logic [3:0] dat_ff;
    logic [3:0] flt_ff;
    logic [3:0] fct_ff;
    logic       ten_ff;
    logic       upf_ff;
    wire        take = clk_en & reg_req.wr;
    wire        w_dat = take && reg_req.addr == LOW_PORT_OUTPUT_DATA_ADDR;
    wire        w_flt = take && reg_req.addr == LOW_PORT_FLOAT_CONTROL_ADDR;
    wire        w_fct = take && reg_req.addr == CLOCK_OUT_CONTROL_ADDR;
    wire        w_ten = take && reg_req.addr == TIMER_OUT_CONTROL_ADDR;
    wire        w_upf = take && reg_req.addr == HIGH_PORT_FLOAT_CONTROL_ADDR;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {ok_ff, dat_ff, flt_ff, fct_ff, ten_ff, upf_ff} <= '0;
        end else begin
            ok_ff <= clk_en;
            if (w_dat) dat_ff <= reg_req.wdata;
            if (w_flt) flt_ff <= reg_req.wdata;
            if (w_fct) fct_ff <= reg_req.wdata;
            if (w_ten) ten_ff <= reg_req.wdata[0];
            if (w_upf) upf_ff <= reg_req.wdata[0];
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_rdata_idle_zero: assert property (ok_ff
        && !$past(reg_req.rd) |-> reg_rdata == 4'h0)
        else $error("read data not zero outside a read answer");
    a_high_unused_zero: assert property (ok_ff && $past(reg_req.rd)
        && $past(reg_req.addr) == HIGH_PORT_FLOAT_CONTROL_ADDR |-> reg_rdata[3:1] == 3'h0)
        else $error("unused upper float bits read nonzero");
    a_low_level_follow: assert property (ok_ff
        |-> low_pins.level[1:0] == $past(dat_ff[1:0]))
        else $error("port bits 1..0 level differs from data");
    a_float_drive: assert property (ok_ff |-> low_pins.drive == ~$past(flt_ff))
        else $error("low pin drive differs from float control");
    a_timer_off_dc: assert property (ok_ff && !$past(ten_ff)
        |-> low_pins.level[2] == $past(dat_ff[2]))
        else $error("port bit 2 not steady with timer clock off");
    a_freq_off_low: assert property (ok_ff && !$past(fct_ff[3]) |-> !low_pins.level[3])
        else $error("port bit 3 high with frequency clock off");
    a_data_zero_low: assert property (ok_ff
        |-> (low_pins.level[3:2] & ~$past(dat_ff[3:2])) == 2'b00)
        else $error("clock pin high while its data bit is zero");
    a_upper_drive: assert property (ok_ff
        |-> upper_nibble_outputs.drive == {4{~$past(upf_ff)}})
        else $error("upper pins drive differs from upper float bit");
    a_upper_level: assert property (ok_ff
        |-> upper_nibble_outputs.level == $past(upper_nibble_data))
        else $error("upper pin level differs from upper data");
    c_timer_low: cover property (ok_ff && $past(ten_ff) && !low_pins.level[2]);
    c_freq_high: cover property (ok_ff && $past(fct_ff[3]) && low_pins.level[3]);
    c_upper_float: cover property (ok_ff && upper_nibble_outputs.drive == 4'h0);
endmodule

bind output_port_special_clock_out outport_monitor i_outport_monitor (.clock(clock), .rst(rst),
    .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .timer_clock_output(timer_clock_output), .slow_osc_clock(slow_osc_clock),
    .fast_osc_clock(fast_osc_clock), .upper_nibble_data(upper_nibble_data),
    .low_pins(low_pins), .upper_nibble_outputs(upper_nibble_outputs));

/* testbench/pin_receiver.sv */
// Model of the external device receiving the port pins
module pin_receiver
    import outport_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    clr,
    input  wire outport_pkg::pin_group_s low_pins,
    output int                           rise2,
    output int                           rise3
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wire_lvl;
    logic [3:0] last_ff = 4'h0;
    logic [3:0] prev_ff = 4'h0;
    // Undriven pins show the inverse of the last driven level
    assign wire_lvl = (low_pins.level & low_pins.drive) | (~last_ff & ~low_pins.drive);
    // Edges are only counted; a short switching pulse is tolerated
    always_ff @(posedge clock) begin
        last_ff <= (low_pins.level & low_pins.drive) | (last_ff & ~low_pins.drive);
        prev_ff <= wire_lvl;
        rise2 <= clr ? 0 : rise2 + int'(wire_lvl[2] & ~prev_ff[2]);
        rise3 <= clr ? 0 : rise3 + int'(wire_lvl[3] & ~prev_ff[3]);
    end
endmodule

/* testbench/output_port_special_clock_out_bench.sv */
// Self-checking bench for the output port block
module output_port_special_clock_out_bench
    import outport_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WIN = 1280;
    logic       clock, rst, clk_en, tclk, sclk, fclk, clr, rd_d;
    reg_req_s   reg_req;
    logic [3:0] reg_rdata, up_data, exp_q[$], sh[5];
    pin_group_s low_pins, up_pins;
    int         rise2, rise3, failures, comparisons, cycles;
    logic [31:0] seed;
    logic [15:0] regs[5] = '{CLOCK_OUT_CONTROL_ADDR, LOW_PORT_FLOAT_CONTROL_ADDR,
        LOW_PORT_OUTPUT_DATA_ADDR, HIGH_PORT_FLOAT_CONTROL_ADDR, TIMER_OUT_CONTROL_ADDR};
    logic [3:0] masks[5] = '{4'hF, 4'hF, 4'hF, 4'h1, 4'h1};
    int         exp3[4] = '{WIN / 512, WIN / 64, WIN / 8, WIN / 4};
    output_port_special_clock_out i_output_port_special_clock_out (.clock(clock), .rst(rst),
        .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .timer_clock_output(tclk), .slow_osc_clock(sclk), .fast_osc_clock(fclk),
        .upper_nibble_data(up_data), .low_pins(low_pins), .upper_nibble_outputs(up_pins));
    pin_receiver i_pin_receiver (.clock(clock), .clr(clr), .low_pins(low_pins),
        .rise2(rise2), .rise3(rise3));
    // ----------------------------------------------------------------
    // Clocks; oscillators and timer run from time zero
    // ----------------------------------------------------------------
    initial begin clock = 0; forever #5 clock = ~clock; end
    initial begin sclk = 0; #3; forever #40 sclk = ~sclk; end
    initial begin fclk = 0; #7; forever #20 fclk = ~fclk; end
    initial begin tclk = 0; #11; forever #30 tclk = ~tclk; end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic near(input int got, input int want);
        near = (got - want <= 1) && (want - got <= 1);
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge clock);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [3:0] e);
        @(posedge clock);
        exp_q.push_back(e);
        reg_req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        reg_req.rd <= 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic window();
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        repeat (WIN) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Result watcher and timeout
    // ----------------------------------------------------------------
    always @(posedge clock) rd_d <= reg_req.rd & clk_en;
    always @(negedge clock) begin
        if (rd_d === 1'b1) begin
            check("read data", reg_rdata, exp_q.pop_front());
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1; clk_en = 1; clr = 0; up_data = 4'h0; reg_req = '0;
        seed = 32'h2A56; failures = 0; comparisons = 0;
        repeat (2) @(posedge clock);
        check("pins in reset", {low_pins, up_pins.drive}, 12'h0FF);
        rst <= 1'b0;
        foreach (regs[i]) rd(regs[i], 4'h0);
        foreach (regs[i]) begin
            seed = lfsr(seed);
            sh[i] = seed[3:0] & masks[i];
            wr(regs[i], seed[3:0]);
            rd(regs[i], sh[i]);
        end
        rd(16'hFF07, 4'h0);
        @(posedge clock);
        clk_en <= 1'b0;
        wr(LOW_PORT_OUTPUT_DATA_ADDR, ~sh[2]);
        clk_en <= 1'b1;
        rd(LOW_PORT_OUTPUT_DATA_ADDR, sh[2]);
        // Special use keeps data one and float zero
        wr(LOW_PORT_OUTPUT_DATA_ADDR, 4'hF);
        wr(LOW_PORT_FLOAT_CONTROL_ADDR, 4'h0);
        wr(CLOCK_OUT_CONTROL_ADDR, 4'h4);
        wr(TIMER_OUT_CONTROL_ADDR, 4'h0);
        wr(HIGH_PORT_FLOAT_CONTROL_ADDR, 4'hF);
        seed = lfsr(seed);
        up_data <= seed[3:0];
        settle();
        check("low pins", low_pins, 8'h7F);
        check("upper pins", up_pins, {seed[3:0], 4'h0});
        wr(LOW_PORT_FLOAT_CONTROL_ADDR, 4'h5);
        wr(HIGH_PORT_FLOAT_CONTROL_ADDR, 4'h0);
        settle();
        check("float drives", {low_pins.drive, up_pins.drive}, 8'hAF);
        wr(LOW_PORT_FLOAT_CONTROL_ADDR, 4'h0);
        for (int s = 0; s < 4; s++) begin
            wr(CLOCK_OUT_CONTROL_ADDR, {2'b10, s[1:0]});
            window();
            check("bit3 clock count", near(rise3, exp3[s]), 1'b1);
        end
        wr(LOW_PORT_FLOAT_CONTROL_ADDR, 4'h8);
        settle();
        check("bit3 released", low_pins.drive, 4'h7);
        wr(LOW_PORT_FLOAT_CONTROL_ADDR, 4'h0);
        wr(LOW_PORT_OUTPUT_DATA_ADDR, 4'h7);
        window();
        check("bit3 data zero", rise3, 0);
        wr(LOW_PORT_OUTPUT_DATA_ADDR, 4'hF);
        wr(TIMER_OUT_CONTROL_ADDR, 4'h1);
        window();
        check("bit2 clock count", near(rise2, WIN * 10 / 60), 1'b1);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(LOW_PORT_OUTPUT_DATA_ADDR, 4'h0);
        rd(TIMER_OUT_CONTROL_ADDR, 4'h0);
        repeat (3) @(posedge clock);
        tally_and_finish();
    end
endmodule
